/* File: logic/bus_mgmt_pkg.sv */
// constants for the bus-management swap and rom header register bank
package bus_mgmt_pkg;
  localparam logic [7:0]  OFS_SWAP_DATA    = 8'h0c;
  localparam logic [7:0]  OFS_SWAP_COMPARE = 8'h10;
  localparam logic [7:0]  OFS_SWAP_CONTROL = 8'h14;
  localparam logic [7:0]  OFS_ROM_HEADER   = 8'h18;
  localparam logic [7:0]  OFS_BUS_IDENT    = 8'h1c;
  localparam logic [7:0]  OFS_BUS_OPTIONS  = 8'h20;
  localparam logic [7:0]  ROM_Q_HEADER     = 8'h00;
  localparam logic [7:0]  ROM_Q_BUS_IDENT  = 8'h01;
  localparam logic [7:0]  ROM_Q_BUS_OPT    = 8'h02;
  localparam int          DONE_BIT         = 31;
  localparam logic [1:0]  SEL_BUS_MANAGER  = 2'h0;
  localparam logic [1:0]  SEL_BANDWIDTH    = 2'h1;
  localparam logic [1:0]  SEL_CHANNELS_HI  = 2'h2;
  localparam logic [1:0]  SEL_CHANNELS_LO  = 2'h3;
  localparam logic [31:0] BUS_IDENT_VALUE  = 32'h31333934;
  localparam logic [31:0] ROM_HEADER_RESET = 32'h00000000;
  localparam logic [31:0] BUS_OPT_WR_MASK  = 32'hf8fff0c0;
  localparam logic [31:0] BUS_OPT_FIXED    = 32'h00000002;
  localparam logic [31:0] BUS_OPT_RESET    = 32'h0000a002;
  localparam logic [31:0] MAX_REC_MASK     = 32'h0000f000;
  localparam logic [15:0] CRC_RESET        = 16'h0000;
  localparam logic [31:0] RES_BUS_MANAGER_RESET = 32'h0000003f;
  localparam logic [31:0] RES_BANDWIDTH_RESET   = 32'h00001333;
  localparam logic [31:0] RES_CHANNELS_RESET    = 32'hffffffff;
  typedef enum logic [1:0] {
    SWAP_IDLE = 2'b01,
    SWAP_BUSY = 2'b10
  } swap_state_e;
endpackage

/* File: logic/compare_swap_engine.sv */
// four bus-management resources with a one-shot compare-swap
`timescale 1ns/1ps
`default_nettype none
module compare_swap_engine
  import bus_mgmt_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // request
  input  wire logic        start_in,
  input  wire logic [1:0]  select_in,
  input  wire logic [31:0] swap_data_in,
  input  wire logic [31:0] swap_compare_in,
  // answer
  output logic             done_out,
  output logic [31:0]      old_value_out
);
  swap_state_e state_reg;
  swap_state_e state_next;
  logic [31:0] res_reg [4];
  logic [31:0] res_next [4];
  logic [1:0]  sel_reg;
  logic [1:0]  sel_next;
  logic        done_next;
  logic [31:0] old_next;

  always_comb
  begin
    state_next = state_reg;
    sel_next   = sel_reg;
    done_next  = 1'b0;
    old_next   = old_value_out;
    for (int i = 0; i < 4; i++)
    begin
      res_next[i] = res_reg[i];
    end
    case (state_reg)
      SWAP_IDLE:
      begin
        if (start_in)
        begin
          sel_next   = select_in;
          state_next = SWAP_BUSY;
        end
      end
      SWAP_BUSY:
      begin
        // store data only on a match
        old_next = res_reg[sel_reg];
        if (res_reg[sel_reg] == swap_compare_in)
        begin
          res_next[sel_reg] = swap_data_in;
        end
        done_next  = 1'b1;
        state_next = SWAP_IDLE;
        if (start_in)
        begin
          sel_next   = select_in;
          state_next = SWAP_BUSY;
        end
      end
      default:
      begin
        state_next = SWAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      state_reg     <= SWAP_IDLE;
      sel_reg       <= SEL_BUS_MANAGER;
      done_out      <= 1'b0;
      old_value_out <= 32'h00000000;
      res_reg[SEL_BUS_MANAGER] <= RES_BUS_MANAGER_RESET;
      res_reg[SEL_BANDWIDTH]   <= RES_BANDWIDTH_RESET;
      res_reg[SEL_CHANNELS_HI] <= RES_CHANNELS_RESET;
      res_reg[SEL_CHANNELS_LO] <= RES_CHANNELS_RESET;
    end
    else
    begin
      state_reg     <= state_next;
      sel_reg       <= sel_next;
      done_out      <= done_next;
      old_value_out <= old_next;
      for (int i = 0; i < 4; i++)
      begin
        res_reg[i] <= res_next[i];
      end
    end
  end
endmodule
`default_nettype wire

/* File: logic/bus_mgmt_csr_and_rom_header_regs.sv */
// host register bank for compare-swap control and config rom header quadlets
`timescale 1ns/1ps
`default_nettype none
module bus_mgmt_csr_and_rom_header_regs
  import bus_mgmt_pkg::*;
(
  // clock and resets
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        soft_rst_in,
  // host register port
  input  wire logic [7:0]  host_addr_in,
  input  wire logic        host_wr_in,
  input  wire logic        host_rd_in,
  input  wire logic [31:0] host_wdata_in,
  output logic [31:0]      host_rdata_out,
  output logic             host_rvalid_out,
  // remote config rom read port, quadlet index
  input  wire logic [7:0]  rom_addr_in,
  input  wire logic        rom_rd_in,
  output logic [31:0]      rom_rdata_out,
  output logic             rom_rvalid_out,
  // serial rom crc load
  input  wire logic        srom_present_in,
  input  wire logic        srom_crc_valid_in,
  input  wire logic [15:0] srom_crc_in,
  // status
  output logic             swap_completion_flag_out
);
  logic [31:0] swap_data_reg;
  logic [31:0] swap_data_next;
  logic [31:0] swap_compare_reg;
  logic [31:0] swap_compare_next;
  logic [1:0]  resource_select_reg;
  logic [1:0]  resource_select_next;
  logic        done_flag_next;
  logic        swap_start_reg;
  logic        swap_start_next;
  logic [31:0] rom_header_reg;
  logic [31:0] rom_header_next;
  logic [31:0] bus_options_reg;
  logic [31:0] bus_options_next;
  logic        crc_pending_reg;
  logic        crc_pending_next;
  logic [31:0] host_rdata_next;
  logic [31:0] rom_rdata_next;
  logic        engine_done;
  logic [31:0] engine_old;

  compare_swap_engine compare_swap_engine_inst (
    .sys_clk_in      (sys_clk_in),
    .rst_in          (rst_in),
    .start_in        (swap_start_reg),
    .select_in       (resource_select_reg),
    .swap_data_in    (swap_data_reg),
    .swap_compare_in (swap_compare_reg),
    .done_out        (engine_done),
    .old_value_out   (engine_old)
  );

  function automatic logic is_wr(input logic [7:0] ofs);
    is_wr = host_wr_in && (host_addr_in == ofs);
  endfunction

  always_comb
  begin
    swap_data_next       = swap_data_reg;
    swap_compare_next    = swap_compare_reg;
    resource_select_next = resource_select_reg;
    done_flag_next       = swap_completion_flag_out;
    swap_start_next      = 1'b0;
    rom_header_next      = rom_header_reg;
    bus_options_next     = bus_options_reg;
    crc_pending_next     = crc_pending_reg;
    if (is_wr(OFS_SWAP_DATA))
    begin
      swap_data_next = host_wdata_in;
    end
    if (is_wr(OFS_SWAP_COMPARE))
    begin
      swap_compare_next = host_wdata_in;
    end
    // old value comes back through the data register
    if (engine_done)
    begin
      swap_data_next = engine_old;
    end
    if (is_wr(OFS_SWAP_CONTROL))
    begin
      resource_select_next = host_wdata_in[1:0];
      done_flag_next       = 1'b0;
      swap_start_next      = 1'b1;
    end
    // completion sets done, set beats clear
    if (engine_done)
    begin
      done_flag_next = 1'b1;
    end
    if (is_wr(OFS_ROM_HEADER))
    begin
      rom_header_next  = host_wdata_in;
      crc_pending_next = 1'b0;
    end
    // one crc load from serial rom
    if (crc_pending_reg && srom_present_in && srom_crc_valid_in)
    begin
      rom_header_next[15:0] = srom_crc_in;
      crc_pending_next      = 1'b0;
    end
    if (is_wr(OFS_BUS_OPTIONS))
    begin
      bus_options_next = (host_wdata_in & BUS_OPT_WR_MASK) | BUS_OPT_FIXED;
    end
    if (soft_rst_in)
    begin
      bus_options_next = (bus_options_reg & MAX_REC_MASK) | BUS_OPT_FIXED;
    end
    host_rdata_next = 32'h00000000;
    case (host_addr_in)
      OFS_SWAP_DATA:    host_rdata_next = swap_data_reg;
      OFS_SWAP_COMPARE: host_rdata_next = swap_compare_reg;
      OFS_SWAP_CONTROL: host_rdata_next = {swap_completion_flag_out, 29'h00000000, resource_select_reg};
      OFS_ROM_HEADER:   host_rdata_next = rom_header_reg;
      OFS_BUS_IDENT:    host_rdata_next = BUS_IDENT_VALUE;
      OFS_BUS_OPTIONS:  host_rdata_next = bus_options_reg;
      default:          host_rdata_next = 32'h00000000;
    endcase
    rom_rdata_next = 32'h00000000;
    case (rom_addr_in)
      ROM_Q_HEADER:    rom_rdata_next = rom_header_reg;
      ROM_Q_BUS_IDENT: rom_rdata_next = BUS_IDENT_VALUE;
      // options as second bus info quadlet
      ROM_Q_BUS_OPT:   rom_rdata_next = bus_options_reg;
      default:         rom_rdata_next = 32'h00000000;
    endcase
  end

  // hard reset only; soft reset is handled as a plain input above
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      swap_data_reg            <= 32'h00000000;
      swap_compare_reg         <= 32'h00000000;
      resource_select_reg      <= SEL_BUS_MANAGER;
      swap_completion_flag_out <= 1'b0;
      swap_start_reg           <= 1'b0;
      rom_header_reg           <= ROM_HEADER_RESET;
      bus_options_reg          <= BUS_OPT_RESET;
      crc_pending_reg          <= 1'b1;
      host_rdata_out           <= 32'h00000000;
      host_rvalid_out          <= 1'b0;
      rom_rdata_out            <= 32'h00000000;
      rom_rvalid_out           <= 1'b0;
    end
    else
    begin
      swap_data_reg            <= swap_data_next;
      swap_compare_reg         <= swap_compare_next;
      resource_select_reg      <= resource_select_next;
      swap_completion_flag_out <= done_flag_next;
      swap_start_reg           <= swap_start_next;
      rom_header_reg           <= rom_header_next;
      bus_options_reg          <= bus_options_next;
      crc_pending_reg          <= crc_pending_next;
      host_rdata_out           <= host_rd_in ? host_rdata_next : 32'h00000000;
      host_rvalid_out          <= host_rd_in;
      rom_rdata_out            <= rom_rd_in ? rom_rdata_next : 32'h00000000;
      rom_rvalid_out           <= rom_rd_in;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/bus_mgmt_props.sv */
// assertions on the swap and rom header register bank ports
`timescale 1ns/1ps
`default_nettype none
module bus_mgmt_props
  import bus_mgmt_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  // watched ports
  input wire logic [7:0]  host_addr_in,
  input wire logic        host_wr_in,
  input wire logic        host_rd_in,
  input wire logic [31:0] host_rdata_out,
  input wire logic [7:0]  rom_addr_in,
  input wire logic        rom_rd_in,
  input wire logic [31:0] rom_rdata_out,
  input wire logic        rom_rvalid_out,
  input wire logic        swap_completion_flag_out
);
  default clocking dc @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  logic       ctl_wr;
  logic [2:0] since_reg;
  logic [2:0] since_next;
  assign ctl_wr = host_wr_in && host_addr_in == OFS_SWAP_CONTROL;
  // cycles since last control write, saturating so a lone write is recognised
  always_comb
  begin
    since_next = since_reg;
    if (ctl_wr)
      since_next = 3'h0;
    else if (since_reg != 3'h7)
      since_next = since_reg + 3'h1;
  end
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      since_reg <= 3'h7;
    else
      since_reg <= since_next;
  end
  ident_read_a: assert property (host_rd_in && host_addr_in == OFS_BUS_IDENT |=> host_rdata_out == BUS_IDENT_VALUE)
    else $error("bus id host read wrong");
  rom_ident_a: assert property (rom_rd_in && rom_addr_in == ROM_Q_BUS_IDENT |=> rom_rdata_out == BUS_IDENT_VALUE)
    else $error("bus id rom read wrong");
  ctl_rsvd_a: assert property (host_rd_in && host_addr_in == OFS_SWAP_CONTROL |=> host_rdata_out[30:2] == 29'h0)
    else $error("control reserved bits set");
  opt_fixed_a: assert property (host_rd_in && host_addr_in == OFS_BUS_OPTIONS |=> (host_rdata_out & 32'h07000f3f) == BUS_OPT_FIXED)
    else $error("bus options fixed bits wrong");
  rom_opt_a: assert property (rom_rd_in && rom_addr_in == ROM_Q_BUS_OPT |=> (rom_rdata_out & 32'h07000f3f) == BUS_OPT_FIXED)
    else $error("rom bus options fixed bits wrong");
  rom_valid_a: assert property (rom_rd_in |=> rom_rvalid_out)
    else $error("rom read not answered");
  wr_clear_a: assert property (ctl_wr && since_reg == 3'h7 |=> !swap_completion_flag_out)
    else $error("flag not cleared by write");
  done_time_a: assert property (ctl_wr && since_reg == 3'h7 |=> (!swap_completion_flag_out)[*3] ##1 swap_completion_flag_out)
    else $error("swap done late or early");
  rise_cause_a: assert property ($rose(swap_completion_flag_out) |-> since_reg == 3'h3)
    else $error("flag rose without a swap");
  flag_hold_a: assert property (swap_completion_flag_out && !ctl_wr |=> swap_completion_flag_out)
    else $error("flag dropped without write");
  cover property ($rose(swap_completion_flag_out));
  cover property (rom_rd_in && rom_addr_in == ROM_Q_HEADER);
  cover property (ctl_wr && swap_completion_flag_out);
endmodule
`default_nettype wire

/* File: testbench/srom_model.sv */
// serial rom model handing over the header crc once after reset
`timescale 1ns/1ps
`default_nettype none
module srom_model
#(
  parameter logic [15:0] CRC = 16'h5a5a
)
(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // crc load
  output logic             srom_present_out,
  output logic             srom_crc_valid_out,
  output logic [15:0]      srom_crc_out
);
  logic [3:0] cnt_reg;
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      cnt_reg <= 4'h0;
    else if (cnt_reg != 4'hf)
      cnt_reg <= cnt_reg + 4'h1;
  end
  assign srom_present_out = 1'b1;
  assign srom_crc_valid_out = cnt_reg == 4'h3;
  // inverted off the pulse so a stale value is never taken
  assign srom_crc_out = srom_crc_valid_out ? CRC : ~CRC;
endmodule
`default_nettype wire

/* File: testbench/tb_bus_mgmt_csr_and_rom_header_regs.sv */
// self-checking bench for the swap and rom header register bank
`timescale 1ns/1ps
`default_nettype none
module tb_bus_mgmt_csr_and_rom_header_regs
  import bus_mgmt_pkg::*;
;
  localparam logic [15:0] CRC_VAL = 16'h5a5a;
  logic        sys_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        soft_rst_in = 1'b0;
  logic [7:0]  host_addr_in = 8'h00;
  logic        host_wr_in = 1'b0;
  logic        host_rd_in = 1'b0;
  logic [31:0] host_wdata_in = 32'h0;
  logic [7:0]  rom_addr_in = 8'h00;
  logic        rom_rd_in = 1'b0;
  logic [31:0] host_rdata_out;
  logic        host_rvalid_out;
  logic [31:0] rom_rdata_out;
  logic        rom_rvalid_out;
  logic        swap_completion_flag_out;
  logic        sp;
  logic        sv;
  logic [15:0] sc;
  int          n_errors = 0;
  int          compares = 0;
  logic [31:0] rv [4] = '{RES_BUS_MANAGER_RESET, RES_BANDWIDTH_RESET, RES_CHANNELS_RESET, RES_CHANNELS_RESET};
  bus_mgmt_csr_and_rom_header_regs bus_mgmt_csr_and_rom_header_regs_inst (.sys_clk_in, .rst_in, .soft_rst_in,
    .host_addr_in, .host_wr_in, .host_rd_in, .host_wdata_in, .host_rdata_out, .host_rvalid_out, .rom_addr_in,
    .rom_rd_in, .rom_rdata_out, .rom_rvalid_out, .srom_present_in(sp), .srom_crc_valid_in(sv), .srom_crc_in(sc),
    .swap_completion_flag_out);
  srom_model #(.CRC(CRC_VAL)) srom_model_inst (.sys_clk_in, .rst_in, .srom_present_out(sp),
    .srom_crc_valid_out(sv), .srom_crc_out(sc));
  task automatic final_report;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    host_addr_in <= a;
    host_wdata_in <= d;
    host_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    host_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic r, input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_in);
    host_addr_in <= a;
    rom_addr_in <= a;
    host_rd_in <= !r;
    rom_rd_in <= r;
    @(posedge sys_clk_in);
    host_rd_in <= 1'b0;
    rom_rd_in <= 1'b0;
    // read data stands for one cycle only, so look right after the sampling edge
    #1;
    chk(r ? "rom_rdata_out" : "host_rdata_out", e, r ? rom_rdata_out : host_rdata_out);
    chk(r ? "rom_rvalid_out" : "host_rvalid_out", 32'h1, {31'h0, r ? rom_rvalid_out : host_rvalid_out});
  endtask
  task automatic swap(input logic [31:0] d);
    wr(OFS_SWAP_CONTROL, d);
    @(posedge sys_clk_in);
    #1;
    chk("flag", 32'h0, {31'h0, swap_completion_flag_out});
    repeat (3) @(posedge sys_clk_in);
    #1;
    chk("flag", 32'h1, {31'h0, swap_completion_flag_out});
  endtask
  initial
  begin
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk_in);
    n_errors++;
    final_report();
  end
  initial
  begin
    repeat (8) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    rd(1'b0, OFS_ROM_HEADER, {ROM_HEADER_RESET[31:16], CRC_VAL});
    rd(1'b0, OFS_BUS_IDENT, BUS_IDENT_VALUE);
    wr(OFS_BUS_IDENT, 32'h0);
    rd(1'b0, OFS_BUS_IDENT, BUS_IDENT_VALUE);
    rd(1'b0, OFS_BUS_OPTIONS, 32'h0000a002);
    rd(1'b0, OFS_SWAP_CONTROL, 32'h0);
    rd(1'b0, 8'h40, 32'h0);
    wr(OFS_BUS_OPTIONS, 32'hffffffff);
    rd(1'b0, OFS_BUS_OPTIONS, 32'hf8fff0c2);
    rd(1'b1, ROM_Q_BUS_OPT, 32'hf8fff0c2);
    @(posedge sys_clk_in);
    soft_rst_in <= 1'b1;
    @(posedge sys_clk_in);
    soft_rst_in <= 1'b0;
    rd(1'b0, OFS_BUS_OPTIONS, 32'h0000f002);
    wr(OFS_ROM_HEADER, 32'h1234abcd);
    rd(1'b1, ROM_Q_HEADER, 32'h1234abcd);
    rd(1'b1, ROM_Q_BUS_IDENT, BUS_IDENT_VALUE);
    rd(1'b1, 8'h05, 32'h0);
    for (int s = 0; s < 4; s++)
    begin
      wr(OFS_SWAP_DATA, 32'h100 + 32'(s));
      wr(OFS_SWAP_COMPARE, rv[s]);
      swap(32'hfffffffc | 32'(s));
      rd(1'b0, OFS_SWAP_CONTROL, 32'h80000000 | 32'(s));
      rd(1'b0, OFS_SWAP_DATA, rv[s]);
      wr(OFS_SWAP_DATA, 32'h0);
      wr(OFS_SWAP_COMPARE, 32'h0);
      swap(32'(s));
      rd(1'b0, OFS_SWAP_DATA, 32'h100 + 32'(s));
    end
    // mid-run hard reset brings max_rec back and reloads the crc
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    rd(1'b0, OFS_BUS_OPTIONS, BUS_OPT_RESET);
    rd(1'b1, ROM_Q_HEADER, {ROM_HEADER_RESET[31:16], CRC_VAL});
    rd(1'b0, OFS_SWAP_CONTROL, 32'h0);
    final_report();
  end
endmodule
bind bus_mgmt_csr_and_rom_header_regs bus_mgmt_props bus_mgmt_props_inst (.sys_clk_in, .rst_in, .host_addr_in,
  .host_wr_in, .host_rd_in, .host_rdata_out, .rom_addr_in, .rom_rd_in, .rom_rdata_out, .rom_rvalid_out,
  .swap_completion_flag_out);
`default_nettype wire
